/* File: core/mtc_pkg.sv */
// Constants shared by the transfer controller, its subchannels, the link monitor and the testbench
package mtc_pkg;
  // ==========================================================================
  // Link geometry
  localparam int NCH = 16;
  localparam int W   = 16;
  localparam int FIFO_DEPTH = 32;
  // ==========================================================================
  // Timing, in ns, and derived cycle counts
  localparam int CLK_NS        = 10;
  localparam int T_IN_STD_NS   = 3100;
  localparam int T_IN_HS_NS    = 1300;
  localparam int T_HOLD_NS     = 500;
  localparam int T_DROP_STD_NS = 5120;
  localparam int T_DROP_HS_NS  = 1920;
  localparam int CW            = 10;
  localparam logic [CW-1:0] IN_STD_CYC   = CW'((T_IN_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] IN_HS_CYC    = CW'((T_IN_HS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] STROBE_CYC   = CW'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] DROP_STD_CYC = CW'((T_DROP_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] DROP_HS_CYC  = CW'((T_DROP_HS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] REDUND_GAP   = 10'h002;
  localparam logic [CW-1:0] REDUND_CYC   = 10'h005;
  // ==========================================================================
  // Controller states
  typedef enum logic [2:0] {
    C_IDLE   = 3'b000,
    C_WAIT   = 3'b001,
    C_STROBE = 3'b010,
    C_HOLD   = 3'b011,
    C_REDUND = 3'b100
  } mtc_state_t;
endpackage

/* File: core/mtc_if.sv */
// Link between the transfer controller and its subchannels
`timescale 1ns/100ps
interface mtc_if #(
  parameter int NCH = 16,
  parameter int W   = 16
);
  logic [NCH-1:0] channel_grant_n;
  logic           transfer_strobe_n;
  logic           range_end_notice_n;
  logic [W-1:0]   outbound_data_bus;
  logic           channel_request_n [NCH];
  logic [W-1:0]   inb_o             [NCH];
  logic           inb_oe            [NCH];
  logic           early_o           [NCH];
  logic           early_oe          [NCH];
  logic [NCH-1:0] request_vec;
  logic [W-1:0]   inbound_data_bus_n;
  logic           early_stop_notice_n;

  // ==========================================================================
  // Wired-AND resolution of the shared low-active lines
  always_comb begin
    inbound_data_bus_n  = '1;
    early_stop_notice_n = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      request_vec[i] = channel_request_n[i];
      if (inb_oe[i]) begin
        inbound_data_bus_n = inbound_data_bus_n & inb_o[i];
      end
      if (early_oe[i]) begin
        early_stop_notice_n = early_stop_notice_n & early_o[i];
      end
    end
  end

  modport ctrl (
    output channel_grant_n,
    output transfer_strobe_n,
    output range_end_notice_n,
    output outbound_data_bus,
    input  request_vec,
    input  inbound_data_bus_n,
    input  early_stop_notice_n
  );
  modport sub (
    input  channel_grant_n,
    input  transfer_strobe_n,
    input  range_end_notice_n,
    input  outbound_data_bus,
    input  inbound_data_bus_n,
    input  early_stop_notice_n,
    output channel_request_n,
    output inb_o,
    output inb_oe,
    output early_o,
    output early_oe
  );
endinterface

/* File: core/mtc_controller.sv */
// Multiplexed transfer controller end: arbitration, grant, strobe and range notice
`timescale 1ns/100ps
module mtc_controller #(
  parameter int NCH = mtc_pkg::NCH,
  parameter int W   = mtc_pkg::W
) (
  input  wire logic           ref_clk,
  input  wire logic           rst,
  mtc_if.ctrl                 bus,
  input  wire logic           mode_output,
  input  wire logic           high_speed,
  input  wire logic           range_end_req,
  input  wire logic           out_valid,
  input  wire logic [W-1:0]   out_data,
  output logic                out_ready,
  output logic                done_valid,
  output logic [3:0]          done_channel,
  output logic [W-1:0]        done_data,
  output logic                done_early
);
  import mtc_pkg::*;

  mtc_state_t      state_q;
  logic [NCH-1:0]  grant_n_q;
  logic            strobe_n_q;
  logic            range_n_q;
  logic [W-1:0]    obus_q;
  logic [3:0]      chan_q;
  logic [CW-1:0]   cnt_q;
  logic [CW-1:0]   tot_q;
  logic            later_q;
  logic            range_q;
  logic            redund_q;
  logic [NCH-1:0]  first_q;
  logic            out_ready_q;
  logic            done_valid_q;
  logic [3:0]      done_chan_q;
  logic [W-1:0]    done_data_q;
  logic            done_early_q;
  logic            hit;
  logic [3:0]      pick;

  // ==========================================================================
  // Fixed priority: lowest index is line 1, the highest
  function automatic logic [4:0] prio(input logic [NCH-1:0] req);
    prio = 5'h00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req[i]) begin
        prio = {1'b1, 4'(i)};
      end
    end
  endfunction

  assign {hit, pick} = prio(bus.request_vec); // R5

  assign bus.channel_grant_n    = grant_n_q;
  assign bus.transfer_strobe_n  = strobe_n_q;
  assign bus.range_end_notice_n = range_n_q;
  assign bus.outbound_data_bus  = obus_q;
  assign out_ready    = out_ready_q;
  assign done_valid   = done_valid_q;
  assign done_channel = done_chan_q;
  assign done_data    = done_data_q;
  assign done_early   = done_early_q;

  // ==========================================================================
  // Transfer sequence
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q    <= C_IDLE;
      grant_n_q  <= '1;
      strobe_n_q <= 1'b1;
      range_n_q  <= 1'b1;
      obus_q     <= '0;
      chan_q     <= 4'h0;
      cnt_q      <= '0;
      tot_q      <= '0;
      later_q    <= 1'b0;
      range_q    <= 1'b0;
      redund_q   <= 1'b0;
    end else begin
      tot_q <= tot_q + 1'b1;
      cnt_q <= cnt_q + 1'b1;
      unique case (state_q)
        C_IDLE: begin
          if (hit && (!mode_output || out_valid)) begin
            grant_n_q       <= '1;
            grant_n_q[pick] <= 1'b0; // R1 R20
            chan_q   <= pick;
            later_q  <= high_speed && !first_q[pick];
            range_q  <= range_end_req;
            redund_q <= 1'b0;
            if (mode_output) begin
              obus_q <= out_data; // R17
            end
            cnt_q   <= '0;
            tot_q   <= '0;
            state_q <= C_WAIT;
          end
        end
        C_WAIT: begin
          if (cnt_q == (later_q ? IN_HS_CYC : IN_STD_CYC) - 1'b1) begin
            strobe_n_q <= 1'b0; // R12 R17
            range_n_q  <= !range_q;
            cnt_q      <= '0;
            state_q    <= C_STROBE;
          end
        end
        C_STROBE: begin
          if (cnt_q == STROBE_CYC - 1'b1) begin
            strobe_n_q <= 1'b1;
            range_n_q  <= 1'b1;
            grant_n_q  <= '1; // R20
            cnt_q      <= '0;
            state_q    <= C_HOLD;
          end
        end
        C_HOLD: begin
          if (tot_q == (later_q ? DROP_HS_CYC : DROP_STD_CYC) - 1'b1) begin
            state_q <= C_IDLE;
          end else if (later_q && !redund_q && cnt_q == REDUND_GAP) begin
            strobe_n_q <= 1'b0;
            cnt_q      <= '0;
            state_q    <= C_REDUND;
          end
        end
        C_REDUND: begin
          if (cnt_q == REDUND_CYC - 1'b1) begin
            strobe_n_q <= 1'b1;
            redund_q   <= 1'b1;
            cnt_q      <= '0;
            state_q    <= C_HOLD;
          end
        end
        default: begin
          state_q <= C_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // First-transfer tracking per channel for the fast timing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_q <= '1;
    end else if (state_q == C_WAIT && cnt_q == '0) begin
      first_q[chan_q] <= range_q || !bus.early_stop_notice_n;
    end else if (state_q == C_STROBE && !bus.early_stop_notice_n) begin
      first_q[chan_q] <= 1'b1;
    end
  end

  // ==========================================================================
  // User side: word accept and transfer report
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_ready_q  <= 1'b0;
      done_valid_q <= 1'b0;
      done_chan_q  <= 4'h0;
      done_data_q  <= '0;
      done_early_q <= 1'b0;
    end else begin
      out_ready_q  <= state_q == C_IDLE && hit && mode_output && out_valid;
      done_valid_q <= state_q == C_WAIT && cnt_q == (later_q ? IN_HS_CYC : IN_STD_CYC) - 1'b1;
      if (state_q == C_WAIT) begin
        done_chan_q  <= chan_q;
        done_early_q <= !bus.early_stop_notice_n; // R9 R10
        if (bus.early_stop_notice_n) begin
          done_data_q <= mode_output ? obus_q : ~bus.inbound_data_bus_n; // R12
        end else begin
          done_data_q <= '0;
        end
      end
    end
  end
endmodule

/* File: core/mtc_subchannel.sv */
// Peripheral subchannel end with its word FIFO
`timescale 1ns/100ps
// Notes on behaviour
// R1: Controller drives winner's grant low, else high
// R2: Input mode: grant puts buffer on inbound
// R3: Output mode: grant and strobe load outbound
// R4: Output mode: never drive inbound on grant
// R5: Sixteen requests, fixed priority, line one first
// R6: Subchannel raises its request to ask
// R7: Range end with grant sets interrupt flag
// R8: Range end stops requests unless auto-switching
// R9: Fast variant: shared early-stop line to controller
// R10: Early-stop line low is one, rests high
// R11: Early stop: request first, assert on grant
// R12: Early-stop transfer moves no data, strobes normally
// R13: Inbound valid by 3.1/1.3 us, hold 0.5
// R14: Strobe trailing edge clears buffer, ready, request
// R15: Request dropped within 5.12/1.92 us of grant
// R16: Strobe after grant withdrawn is ignored
// R17: Controller places outbound word before strobe
// R18: Never load on strobe leading edge
// R19: Mode command sets enable, enabling requests
// R20: One grant at a time, held through strobe
module mtc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int NW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [NW-1:0] cnt_q;
  logic [NW-1:0] cnt_d;
  logic          full_q;
  logic          empty_q;
  logic          push;
  logic          pop;

  assign push      = in_valid && !full_q;
  assign pop       = out_ready && !empty_q;
  assign in_ready  = !full_q;
  assign out_valid = !empty_q;
  assign out_data  = mem[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q   <= cnt_d;
      full_q  <= cnt_d == NW'(DEPTH);
      empty_q <= cnt_d == '0;
    end
  end
endmodule

module mtc_subchannel #(
  parameter int CH    = 0,
  parameter int W     = mtc_pkg::W,
  parameter int DEPTH = mtc_pkg::FIFO_DEPTH
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  mtc_if.sub                bus,
  input  wire logic         mode_output,
  input  wire logic         auto_switch,
  input  wire logic         enable_cmd,
  input  wire logic         stop_req,
  input  wire logic         irq_clr,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  output logic              src_ready,
  output logic              snk_valid,
  output logic [W-1:0]      snk_data,
  input  wire logic         snk_ready,
  output logic              irq_flag,
  output logic              enabled
);
  import mtc_pkg::*;

  logic         granted;
  logic         trail;
  logic         gnt_prev_q;
  logic         stb_prev_q;
  logic         range_seen_q;
  logic         early_sent_q;
  logic [W-1:0] buf_q;
  logic         full_q;
  logic         enable_q;
  logic         stop_q;
  logic         irq_q;
  logic         req_q;
  logic         inb_oe_q;
  logic         early_oe_q;
  logic         f_in_valid;
  logic         f_in_ready;
  logic [W-1:0] f_in_data;
  logic         f_out_valid;
  logic         f_out_ready;
  logic [W-1:0] f_out_data;
  logic         load_buf;

  assign granted = !bus.channel_grant_n[CH];
  // Trailing edge of a strobe seen while our grant stood
  assign trail   = stb_prev_q && bus.transfer_strobe_n && gnt_prev_q; // R16 R18

  assign bus.channel_request_n[CH] = req_q;
  assign bus.inb_o[CH]             = ~buf_q;
  assign bus.inb_oe[CH]            = inb_oe_q;
  assign bus.early_o[CH]           = 1'b0;
  assign bus.early_oe[CH]          = early_oe_q;
  assign irq_flag = irq_q;
  assign enabled  = enable_q;

  // ==========================================================================
  // Word FIFO: user to buffer in input mode, buffer to user in output mode
  assign f_in_valid  = mode_output ? full_q : src_valid;
  assign f_in_data   = mode_output ? buf_q : src_data;
  assign src_ready   = !mode_output && f_in_ready;
  assign snk_valid   = mode_output && f_out_valid;
  assign snk_data    = f_out_data;
  assign load_buf    = !mode_output && !full_q && f_out_valid && !granted && !gnt_prev_q;
  assign f_out_ready = mode_output ? snk_ready : load_buf;

  mtc_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ==========================================================================
  // Link edge tracking
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gnt_prev_q   <= 1'b0;
      stb_prev_q   <= 1'b0;
      range_seen_q <= 1'b0;
      early_sent_q <= 1'b0;
    end else begin
      gnt_prev_q <= granted;
      stb_prev_q <= granted && !bus.transfer_strobe_n;
      if (granted && !bus.range_end_notice_n) begin
        range_seen_q <= 1'b1;
      end else if (trail || !granted) begin
        range_seen_q <= 1'b0;
      end
      if (granted && stop_q) begin
        early_sent_q <= 1'b1;
      end else if (!granted && !gnt_prev_q) begin
        early_sent_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Buffer register and its ready state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_q  <= '0;
      full_q <= 1'b0;
    end else if (trail && !early_sent_q) begin
      buf_q  <= mode_output ? bus.outbound_data_bus : '0; // R3 R14
      full_q <= mode_output;
    end else if (load_buf) begin
      buf_q  <= f_out_data;
      full_q <= 1'b1;
    end else if (mode_output && full_q && f_in_ready) begin
      full_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Enable, early stop and interrupt flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable_q <= 1'b0;
      stop_q   <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      if (enable_cmd) begin
        enable_q <= 1'b1; // R19
      end else if (trail && range_seen_q && !auto_switch) begin
        enable_q <= 1'b0; // R8
      end
      if (stop_req) begin
        stop_q <= 1'b1;
      end else if (trail && early_sent_q) begin
        stop_q <= 1'b0;
      end
      if (trail && range_seen_q) begin
        irq_q <= 1'b1; // R7
      end else if (irq_clr) begin
        irq_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Request and bus drive
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_q      <= 1'b0;
      inb_oe_q   <= 1'b0;
      early_oe_q <= 1'b0;
    end else begin
      // Request falls the cycle after the trailing strobe edge
      req_q <= enable_q && !trail && (stop_q || (mode_output ? !full_q : full_q)); // R6 R11 R14 R15
      inb_oe_q   <= granted && !mode_output && !stop_q; // R2 R4 R13
      early_oe_q <= granted && stop_q; // R9 R10 R11
    end
  end
endmodule

/* File: dv/mtc_link_monitor.sv */
// Checker of the controller-to-subchannel link signals
`timescale 1ns/100ps
module mtc_link_monitor #(
  parameter int NCH = 16,
  parameter int W   = 16
) (
  input wire logic           ref_clk,
  input wire logic           rst,
  input wire logic [NCH-1:0] channel_grant_n,
  input wire logic           transfer_strobe_n,
  input wire logic           range_end_notice_n,
  input wire logic [W-1:0]   outbound_data_bus,
  input wire logic [NCH-1:0] request_vec,
  input wire logic [W-1:0]   inbound_data_bus_n,
  input wire logic           early_stop_notice_n
);
  import mtc_pkg::*;
  logic           idle_w;
  logic [CW-1:0]  glow_q;
  logic [CW-1:0]  slow_q;
  logic [NCH-1:0] gsel_q;

  assign idle_w = &channel_grant_n;

  // ==========================================================================
  // Grant and strobe low time, and the last granted line
  always_ff @(posedge ref_clk) begin
    if (rst || idle_w) begin
      glow_q <= '0;
    end else begin
      glow_q <= glow_q + 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst || transfer_strobe_n) begin
      slow_q <= '0;
    end else begin
      slow_q <= slow_q + 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gsel_q <= '0;
    end else if (!idle_w) begin
      gsel_q <= ~channel_grant_n;
    end
  end

  // ==========================================================================
  // Link properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence grant_start_s;
    $fell(idle_w);
  endsequence
  sequence main_strobe_s;
    $fell(transfer_strobe_n) && !idle_w;
  endsequence

  one_grant_a: assert property ($onehot0(~channel_grant_n))
    else $error("more than one grant low");
  grant_prio_a: assert property (grant_start_s |->
    (~channel_grant_n) == ($past(request_vec) & (~$past(request_vec) + 1'b1)))
    else $error("grant not to highest requesting line");
  strobe_delay_a: assert property (main_strobe_s |->
    (glow_q == IN_STD_CYC || glow_q == IN_HS_CYC))
    else $error("strobe delay after grant wrong");
  strobe_len_a: assert property ($rose(transfer_strobe_n) |->
    (slow_q == STROBE_CYC || slow_q == REDUND_CYC))
    else $error("strobe length wrong");
  grant_release_a: assert property ($rose(idle_w) |-> $rose(transfer_strobe_n))
    else $error("grant not released with strobe end");
  range_window_a: assert property (!range_end_notice_n |-> !transfer_strobe_n && !idle_w)
    else $error("range notice outside granted strobe");
  req_drop_a: assert property (grant_start_s |-> ##[1:512] ((request_vec & gsel_q) == '0))
    else $error("request not dropped in time");
  early_grant_a: assert property ($fell(early_stop_notice_n) |-> !idle_w)
    else $error("early stop without grant");
  inb_hold_a: assert property ((!transfer_strobe_n && !idle_w &&
    $past(transfer_strobe_n) == 1'b0) |-> $stable(inbound_data_bus_n))
    else $error("inbound data moved during strobe");
  otb_stable_a: assert property (!transfer_strobe_n |-> $stable(outbound_data_bus))
    else $error("outbound data moved during strobe");
endmodule

/* File: dv/tb.sv */
// Testbench joining the transfer controller to three subchannels
`timescale 1ns/100ps
module tb;
  import mtc_pkg::*;
  localparam int NS = 3;
  logic          ref_clk;
  logic          rst;
  logic          m_out;
  logic          high_speed;
  logic          range_end_req;
  logic          out_valid;
  logic [W-1:0]  out_data;
  logic          out_ready;
  logic          done_valid;
  logic [3:0]    done_channel;
  logic [W-1:0]  done_data;
  logic          done_early;
  logic [NS-1:0] auto_sw, en_cmd, stop_req, irq_clr, src_valid, src_ready;
  logic [NS-1:0] snk_valid, snk_ready, irq_flag, enabled;
  logic [W-1:0]  src_data [NS];
  logic [W-1:0]  snk_data [NS];
  logic [W+4:0]  iq [$];
  logic [W-1:0]  oq [$];
  logic [W+4:0]  dq [$];
  logic [31:0]   seed;
  logic [W-1:0]  wd;
  int            mismatches;
  int            n_tests;
  int            n;

  mtc_if #(.NCH(NCH), .W(W)) bus ();

  mtc_controller #(.NCH(NCH), .W(W)) mtc_controller_i (.ref_clk(ref_clk), .rst(rst),
    .bus(bus), .mode_output(m_out), .high_speed(high_speed), .range_end_req(range_end_req),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .done_valid(done_valid), .done_channel(done_channel), .done_data(done_data),
    .done_early(done_early));

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    if (c < NS) begin : g_sub
      mtc_subchannel #(.CH(c)) mtc_subchannel_i (.ref_clk(ref_clk), .rst(rst), .bus(bus),
        .mode_output(m_out), .auto_switch(auto_sw[c]), .enable_cmd(en_cmd[c]),
        .stop_req(stop_req[c]), .irq_clr(irq_clr[c]), .src_valid(src_valid[c]),
        .src_data(src_data[c]), .src_ready(src_ready[c]), .snk_valid(snk_valid[c]),
        .snk_data(snk_data[c]), .snk_ready(snk_ready[c]), .irq_flag(irq_flag[c]),
        .enabled(enabled[c]));
    end else begin : g_none
      assign bus.channel_request_n[c] = 1'b0;
      assign bus.inb_o[c]             = '1;
      assign bus.inb_oe[c]            = 1'b0;
      assign bus.early_o[c]           = 1'b1;
      assign bus.early_oe[c]          = 1'b0;
    end
  end

  mtc_link_monitor #(.NCH(NCH), .W(W)) mtc_link_monitor_i (.ref_clk(ref_clk), .rst(rst),
    .channel_grant_n(bus.channel_grant_n), .transfer_strobe_n(bus.transfer_strobe_n),
    .range_end_notice_n(bus.range_end_notice_n), .outbound_data_bus(bus.outbound_data_bus),
    .request_vec(bus.request_vec), .inbound_data_bus_n(bus.inbound_data_bus_n),
    .early_stop_notice_n(bus.early_stop_notice_n));

  // ==========================================================================
  // Clock, helpers and closing
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [W-1:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[W-1:0];
  endfunction

  task automatic fail(input string msg);
    mismatches++;
    $display("MISMATCH t=%0t %s", $time, msg);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic push(input int c, input logic [W-1:0] d, input logic exp);
    src_valid[c] <= 1'b1;
    src_data[c]  <= d;
    for (int i = 0; i < 2000; i++) begin
      @(negedge ref_clk);
      if (src_ready[c] === 1'b1) break;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    src_valid[c] <= 1'b0;
    if (exp) iq.push_back({1'b0, 4'(c), d});
    @(posedge ref_clk);
  endtask

  task automatic send(input logic [W-1:0] d);
    out_valid <= 1'b1;
    out_data  <= d;
    for (int i = 0; i < 4000; i++) begin
      @(negedge ref_clk);
      if (out_ready === 1'b1) break;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    oq.push_back(d);
    dq.push_back({1'b0, 4'h0, d});
  endtask

  task automatic settle();
    for (int i = 0; i < 40000 && (iq.size() + oq.size()) != 0; i++) @(posedge ref_clk);
    n_tests++;
    if (iq.size() + oq.size() != 0) fail("transfers missing");
    repeat (600) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // ==========================================================================
  // Result watcher and far-side stall
  always @(posedge ref_clk) begin
    if (done_valid === 1'b1 && m_out === 1'b0) begin
      n_tests++;
      if (iq.size() == 0) fail("unexpected transfer");
      else if ({done_early, done_channel, done_data} !== iq.pop_front()) fail("input word");
    end
    if (done_valid === 1'b1 && m_out === 1'b1) begin
      n_tests++;
      if (dq.size() == 0) fail("report without word");
      else if ({done_early, done_channel, done_data} !== dq.pop_front()) fail("out word");
    end
    for (int c = 0; c < NS; c++) begin
      if (snk_valid[c] === 1'b1 && snk_ready[c] === 1'b1) begin
        n_tests++;
        if (oq.size() == 0 || snk_data[c] !== oq.pop_front()) fail("output word");
        if (bus.inbound_data_bus_n !== '1) fail("inbound driven in output mode");
      end
    end
  end

  always @(posedge ref_clk) snk_ready <= rst ? '1 : ~snk_ready;

  initial begin
    #600000;
    fail("watchdog");
    end_sim();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h0000_f251;
    rst = 1'b1;
    m_out = 1'b0;
    high_speed = 1'b0;
    range_end_req = 1'b0;
    out_valid = 1'b0;
    out_data = '0;
    {auto_sw, en_cmd, stop_req, irq_clr, src_valid} = '0;
    src_data = '{default: '0};
    mismatches = 0;
    n_tests = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int c = 0; c < 2; c++) begin
      push(c, xs(), 1'b1);
      push(c, xs(), 1'b1);
    end
    n = 0;
    for (int i = 0; i < 34; i++) begin
      @(negedge ref_clk);
      if (src_ready[2] !== 1'b1) break;
      @(posedge ref_clk);
      push(2, xs(), 1'b1);
      n++;
    end
    n_tests++;
    if (n != FIFO_DEPTH + 1) fail("fifo depth");
    @(posedge ref_clk);
    en_cmd <= 3'h7;
    @(posedge ref_clk);
    en_cmd <= 3'h0;
    settle();
    @(posedge ref_clk);
    range_end_req <= 1'b1;
    auto_sw <= 3'h4;
    push(0, xs(), 1'b1);
    push(2, xs(), 1'b1);
    settle();
    n_tests++;
    if (irq_flag !== 3'h5 || enabled !== 3'h6) fail("range end flags");
    @(posedge ref_clk);
    range_end_req <= 1'b0;
    irq_clr <= 3'h5;
    @(posedge ref_clk);
    irq_clr <= 3'h0;
    wd = xs();
    push(0, wd, 1'b0);
    repeat (1000) @(posedge ref_clk);
    @(negedge ref_clk);
    n_tests++;
    if (irq_flag !== 3'h0) fail("interrupt clear");
    @(posedge ref_clk);
    iq.push_back({1'b0, 4'h0, wd});
    en_cmd <= 3'h1;
    @(posedge ref_clk);
    en_cmd <= 3'h0;
    settle();
    @(posedge ref_clk);
    iq.push_back({1'b1, 4'h1, {W{1'b0}}});
    stop_req <= 3'h2;
    @(posedge ref_clk);
    stop_req <= 3'h0;
    settle();
    @(posedge ref_clk);
    high_speed <= 1'b1;
    repeat (4) push(2, xs(), 1'b1);
    settle();
    @(posedge ref_clk);
    m_out <= 1'b1;
    repeat (6) send(xs());
    out_valid <= 1'b0;
    settle();
    end_sim();
  end
endmodule
